// *** logic/avc_framer_pkg.sv ***
// What this block does
// - Channel word bits 31..27 always zero.
// - Bit 26 reports audio coding type.
// - Bits 25..22 carry the video level code.
// - Bit 21 flags metadata present.
// - Bit 20 flags clock reference synced.
// - Bit 19 flags per-packet time stamps.
// - Bits 18..15 profile; reserved codes never emitted.
// - Bit 14 flags embedded time present.
// - Bit 13 reports constant or variable rate.
// - Bit 12 reports transport or program stream.
// - Bits 11..0 count packets in body.
// - Bodies hold whole stream packets only.
// - Unknown packet count is written as zero.
// - Count unit follows the stream kind bit.
// - Stamp header sits directly before each packet.
// - Stamp low word first, high word second.
// - Counter mode: 48-bit time, upper bits zero.
// - Absolute mode uses absolute time, format bits.
// - 27 MHz reference slaved to 10 MHz counter.
// - Reference is 33-bit base times 300 plus extension.
package avc_framer_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int RTC_HZ       = 10_000_000;
  localparam int SCR_HZ       = 27_000_000;
  localparam int RTC_DIV      = CLK_HZ / RTC_HZ;
  localparam int DIV_W        = 4;
  localparam int SCR_NUM      = SCR_HZ / 1_000_000;
  localparam int SCR_DEN      = RTC_HZ / 1_000_000;
  localparam int RTC_W        = 48;
  localparam int SCR_BASE_W   = 33;
  localparam int SCR_EXT_W    = 9;
  localparam int SCR_EXT_MOD  = 300;
  localparam int COUNT_W      = 12;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int ADDR_W                = 5;
  localparam logic [4:0] OFS_CONFIG    = 5'h00;
  localparam logic [4:0] OFS_LIMIT     = 5'h04;
  localparam logic [4:0] OFS_CONTROL   = 5'h08;
  localparam logic [4:0] OFS_STATUS    = 5'h0c;
  localparam logic [4:0] OFS_RTC_LO    = 5'h10;
  localparam logic [4:0] OFS_RTC_HI    = 5'h14;
  localparam logic [4:0] OFS_CHANNEL   = 5'h18;

  // ----------------------------------------------------------------
  // Channel word and configuration field positions
  // ----------------------------------------------------------------
  localparam int CW_AUDIO_BIT   = 26;
  localparam int CW_LEVEL_LSB   = 22;
  localparam int CW_META_BIT    = 21;
  localparam int CW_SYNC_BIT    = 20;
  localparam int CW_STAMP_BIT   = 19;
  localparam int CW_PROF_LSB    = 15;
  localparam int CW_ETIME_BIT   = 14;
  localparam int CW_RATE_BIT    = 13;
  localparam int CW_KIND_BIT    = 12;
  localparam int CODE_W         = 4;
  localparam logic [3:0] PROFILE_MAX = 4'h6;
  localparam int CFG_SCR_EN_BIT = 0;
  localparam int CFG_FMT_LSB    = 2;
  localparam int CFG_FMT_W      = 2;
  localparam int CFG_ABS_BIT    = 6;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h07ff_f04d;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [11:0] LIMIT_RESET    = 12'h000;

  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTL_FLUSH_BIT  = 0;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DROP_BIT    = 1;
  localparam int ST_PROF_BIT    = 2;
  localparam int ST_FLUSH_BIT   = 3;
  localparam int ST_COUNT_LSB   = 16;
  localparam int STAMP_PAD_W    = 16;

  typedef enum logic [4:0] {
    FSM_IDLE     = 5'h01,
    FSM_STAMP_LO = 5'h02,
    FSM_STAMP_HI = 5'h04,
    FSM_DATA     = 5'h08,
    FSM_GAP      = 5'h10
  } fsm_t;

endpackage : avc_framer_pkg

// *** logic/avc_video_packet_framer.sv ***
`timescale 1ns/1ns
module avc_video_packet_framer
  import avc_framer_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Avalon-MM register slave.
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Stream packets from the encoder.
  input  wire logic [DATA_W-1:0]    in_data,
  input  wire logic                 in_valid,
  input  wire logic                 in_sop,
  input  wire logic                 in_eop,
  output logic                      in_ready,
  // Absolute time from the recorder, same clock.
  input  wire logic [63:0]          abs_time,
  // Packet body towards the packet assembler.
  output logic [DATA_W-1:0]         out_data,
  output logic                      out_valid,
  output logic                      out_sop,
  output logic                      out_eop,
  input  wire logic                 out_ready,
  // Time flags and time bases for the packet header.
  output logic                      abs_time_select,
  output logic [CFG_FMT_W-1:0]      time_format,
  output logic [RTC_W-1:0]          rtc_time,
  output logic [SCR_BASE_W-1:0]     scr_base,
  output logic [SCR_EXT_W-1:0]      scr_ext
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fsm_t                   fsm;
    logic                   waitrequest;
    logic [31:0]            readdata;
    logic [31:0]            cfg;
    logic [COUNT_W-1:0]     limit;
    logic                   flush_pend;
    logic                   dropped;
    logic                   prof_rej;
    logic [31:0]            body_cfg;
    logic [COUNT_W-1:0]     body_limit;
    logic [COUNT_W-1:0]     pkt_cnt;
    logic [63:0]            stamp;
    logic [DATA_W-1:0]      out_data;
    logic                   out_valid;
    logic                   out_sop;
    logic                   out_eop;
    logic                   in_ready;
    logic [31:0]            last_cw;
    logic [DIV_W-1:0]       div;
    logic [RTC_W-1:0]       rtc;
    logic [DIV_W-1:0]       scr_acc;
    logic [SCR_BASE_W-1:0]  scr_base;
    logic [SCR_EXT_W-1:0]   scr_ext;
  } state_t;

  localparam state_t STATE_RESET = '{
    fsm:         FSM_IDLE,
    waitrequest: 1'b1,
    cfg:         CFG_RESET,
    limit:       LIMIT_RESET,
    default:     '0
  };

  // All state sits in one register, so reset and
  // clocking are the same for every field.
  state_t state_reg;
  state_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Builds the channel word from a configuration snapshot and a count.
  function automatic logic [31:0] channel_word(input logic [31:0]        c,
                                               input logic [COUNT_W-1:0] n);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CW_AUDIO_BIT] = c[CW_AUDIO_BIT];
    w[CW_LEVEL_LSB +: CODE_W] = c[CW_LEVEL_LSB +: CODE_W];
    w[CW_META_BIT] = c[CW_META_BIT];
    w[CW_SYNC_BIT] = c[CW_SYNC_BIT];
    w[CW_STAMP_BIT] = c[CW_STAMP_BIT];
    w[CW_PROF_LSB +: CODE_W] = c[CW_PROF_LSB +: CODE_W];
    w[CW_ETIME_BIT] = c[CW_ETIME_BIT];
    w[CW_RATE_BIT] = c[CW_RATE_BIT];
    w[CW_KIND_BIT] = c[CW_KIND_BIT];
    w[COUNT_W-1:0] = n;
    return w;
  endfunction : channel_word

  // Captures the time of the first bit of a stream packet.
  function automatic logic [63:0] take_stamp(input logic             abs_sel,
                                             input logic [63:0]      abs_val,
                                             input logic [RTC_W-1:0] rtc_val);
    logic [63:0] t;
    if (abs_sel) begin
      t = abs_val;
    end else begin
      t = {{STAMP_PAD_W{1'b0}}, rtc_val};
    end
    return t;
  endfunction : take_stamp

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // All state is computed here and registered below in one process.
  always_comb begin
    logic                   out_free;
    logic                   take_in;
    logic                   body_end;
    logic                   flush_set;
    logic [COUNT_W-1:0]     cnt_inc;
    logic [DIV_W+1:0]       acc_sum;
    logic [1:0]             scr_step;
    logic [SCR_EXT_W:0]     ext_sum;
    logic [31:0]            cfg_wr;
    logic [31:0]            status;

    state_next = state_reg;
    out_free   = !state_reg.out_valid || out_ready;
    take_in    = in_valid && state_reg.in_ready;
    body_end   = 1'b0;
    flush_set  = 1'b0;
    cnt_inc    = COUNT_W'(state_reg.pkt_cnt + 1'b1);
    acc_sum    = '0;
    scr_step   = '0;
    ext_sum    = '0;
    cfg_wr     = '0;
    status     = '0;

    // Time counter: one tick every RTC_DIV system clocks gives 10 MHz.
    if (state_reg.div == DIV_W'(RTC_DIV - 1)) begin
      state_next.div = '0;
      state_next.rtc = RTC_W'(state_reg.rtc + 1'b1);
      // The 27 MHz reference advances 2.7 counts per time tick, so the
      // fraction is carried in tenths and never drifts from the counter.
      if (state_reg.cfg[CFG_SCR_EN_BIT]) begin
        acc_sum  = (DIV_W+2)'(state_reg.scr_acc) + (DIV_W+2)'(SCR_NUM);
        scr_step = 2'((acc_sum) / (DIV_W+2)'(SCR_DEN));
        state_next.scr_acc = DIV_W'(acc_sum - (DIV_W+2)'(scr_step) * (DIV_W+2)'(SCR_DEN));
        ext_sum  = (SCR_EXT_W+1)'(state_reg.scr_ext) + (SCR_EXT_W+1)'(scr_step);
        if (ext_sum >= (SCR_EXT_W+1)'(SCR_EXT_MOD)) begin
          state_next.scr_ext  = SCR_EXT_W'(ext_sum - (SCR_EXT_W+1)'(SCR_EXT_MOD));
          state_next.scr_base = SCR_BASE_W'(state_reg.scr_base + 1'b1);
        end else begin
          state_next.scr_ext = SCR_EXT_W'(ext_sum);
        end
      end
    end else begin
      state_next.div = DIV_W'(state_reg.div + 1'b1);
    end
    // Limitation: the reference is not preset from the counter.
    // A disabled reference restarts from zero when enabled again.
    if (!state_reg.cfg[CFG_SCR_EN_BIT]) begin
      state_next.scr_acc  = '0;
      state_next.scr_ext  = '0;
      state_next.scr_base = '0;
    end

    // Register slave: one wait cycle, then the answer for one cycle.
    status[ST_BUSY_BIT]  = (state_reg.fsm != FSM_IDLE);
    status[ST_DROP_BIT]  = state_reg.dropped;
    status[ST_PROF_BIT]  = state_reg.prof_rej;
    status[ST_FLUSH_BIT] = state_reg.flush_pend;
    status[ST_COUNT_LSB +: COUNT_W] = state_reg.pkt_cnt;
    // The answer never lasts more than one cycle.
    state_next.waitrequest = 1'b1;
    if ((read || write) && state_reg.waitrequest) begin
      state_next.waitrequest = 1'b0;
      // Writes and unmapped reads answer with zero.
      state_next.readdata    = '0;
      if (read) begin
        case (address)
          OFS_CONFIG:  state_next.readdata = state_reg.cfg;
          OFS_LIMIT:   state_next.readdata = {{(32-COUNT_W){1'b0}}, state_reg.limit};
          OFS_STATUS:  state_next.readdata = status;
          OFS_RTC_LO:  state_next.readdata = state_reg.rtc[31:0];
          OFS_RTC_HI:  state_next.readdata = {{(64-RTC_W){1'b0}}, state_reg.rtc[RTC_W-1:32]};
          OFS_CHANNEL: state_next.readdata = state_reg.last_cw;
          default:     state_next.readdata = '0;
        endcase
      end
    end

    // Writes take effect at the edge where the master sees waitrequest low.
    if (write && !state_reg.waitrequest) begin
      case (address)
        OFS_CONFIG: begin
          cfg_wr = merge_bytes(state_reg.cfg, writedata, byteenable) & CFG_WRITE_MASK;
          // A reserved profile code is refused so it can never be framed.
          if (cfg_wr[CW_PROF_LSB +: CODE_W] > PROFILE_MAX) begin
            cfg_wr[CW_PROF_LSB +: CODE_W] = state_reg.cfg[CW_PROF_LSB +: CODE_W];
            state_next.prof_rej = 1'b1;
          end
          state_next.cfg = cfg_wr;
        end
        OFS_LIMIT: begin
          state_next.limit = COUNT_W'(merge_bytes({{(32-COUNT_W){1'b0}}, state_reg.limit},
                                                  writedata, byteenable));
        end
        OFS_CONTROL: begin
          flush_set = byteenable[0] && writedata[CTL_FLUSH_BIT];
        end
        OFS_STATUS: begin
          // Sticky flags clear by writing one; a new event below still wins.
          if (byteenable[0] && writedata[ST_DROP_BIT]) begin
            state_next.dropped = 1'b0;
          end
          if (byteenable[0] && writedata[ST_PROF_BIT] && state_next.prof_rej == state_reg.prof_rej) begin
            state_next.prof_rej = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Output register drains whenever the assembler takes a word.
    if (state_reg.out_valid && out_ready) begin
      state_next.out_valid = 1'b0;
      state_next.out_sop   = 1'b0;
      state_next.out_eop   = 1'b0;
    end

    // Framing sequence.
    case (state_reg.fsm)
      // Between packets only a start word is accepted.
      FSM_IDLE, FSM_GAP: begin
        if (take_in) begin
          // A word outside a packet is discarded, never framed.
          state_next.dropped = 1'b1;
        end else if (in_valid && in_sop && out_free) begin
          state_next.stamp = take_stamp(state_reg.cfg[CFG_ABS_BIT], abs_time, state_reg.rtc);
          state_next.out_valid = 1'b1;
          state_next.out_eop   = 1'b0;
          if (state_reg.fsm == FSM_IDLE) begin
            // Body opens with the channel word; the count is known only
            // when a fixed body length is set, otherwise it reads zero.
            state_next.body_cfg   = state_reg.cfg;
            state_next.body_limit = state_reg.limit;
            state_next.pkt_cnt    = '0;
            state_next.out_data   = DATA_W'(channel_word(state_reg.cfg, state_reg.limit));
            state_next.last_cw    = channel_word(state_reg.cfg, state_reg.limit);
            state_next.out_sop    = 1'b1;
            state_next.fsm        = state_reg.cfg[CW_STAMP_BIT] ? FSM_STAMP_LO : FSM_DATA;
          end else begin
            state_next.out_valid = 1'b0;
            state_next.fsm       = state_reg.body_cfg[CW_STAMP_BIT] ? FSM_STAMP_LO : FSM_DATA;
          end
        end
      end
      // Stamp words go out back to back.
      FSM_STAMP_LO: begin
        if (out_free) begin
          state_next.out_data  = DATA_W'(state_reg.stamp[31:0]);
          state_next.out_valid = 1'b1;
          state_next.out_sop   = 1'b0;
          state_next.out_eop   = 1'b0;
          state_next.fsm       = FSM_STAMP_HI;
        end
      end
      FSM_STAMP_HI: begin
        if (out_free) begin
          state_next.out_data  = DATA_W'(state_reg.stamp[63:32]);
          state_next.out_valid = 1'b1;
          state_next.out_sop   = 1'b0;
          state_next.out_eop   = 1'b0;
          state_next.fsm       = FSM_DATA;
        end
      end
      // A word is copied out the cycle after it is taken.
      FSM_DATA: begin
        if (take_in) begin
          state_next.out_data  = in_data;
          state_next.out_valid = 1'b1;
          state_next.out_sop   = 1'b0;
          state_next.out_eop   = 1'b0;
          if (in_eop) begin
            // Counts transport packets or program packs by the kind bit.
            state_next.pkt_cnt = cnt_inc;
            // The body may only close on a packet boundary.
            body_end = (state_reg.body_limit != '0 && cnt_inc == state_reg.body_limit) ||
                       (state_reg.body_limit == '0 && state_reg.flush_pend) ||
                       (cnt_inc == '1);
            state_next.out_eop = body_end;
            state_next.fsm     = body_end ? FSM_IDLE : FSM_GAP;
            if (body_end) begin
              state_next.flush_pend = 1'b0;
            end
          end
        end
      end
      default: begin
        state_next.fsm = FSM_IDLE;
      end
    endcase

    // A flush request arriving with the closing word is kept.
    if (flush_set) begin
      state_next.flush_pend = 1'b1;
    end

    // Input is offered only into an empty output register, which halves
    // the rate but keeps in_ready a plain flop; a stray word is popped
    // with one idle cycle after it so a start word is never eaten.
    state_next.in_ready = ((state_next.fsm == FSM_DATA) && !state_next.out_valid) ||
                          ((state_next.fsm == FSM_IDLE || state_next.fsm == FSM_GAP) &&
                           in_valid && !in_sop && !state_reg.in_ready);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Single register for the whole block state.
  // Reset loads constants only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs are plain state fields, never gated.
  assign readdata        = state_reg.readdata;
  assign waitrequest     = state_reg.waitrequest;
  assign in_ready        = state_reg.in_ready;
  assign out_data        = state_reg.out_data;
  assign out_valid       = state_reg.out_valid;
  assign out_sop         = state_reg.out_sop;
  assign out_eop         = state_reg.out_eop;
  // Header time fields pass through as stored.
  assign abs_time_select = state_reg.cfg[CFG_ABS_BIT];
  assign time_format     = state_reg.cfg[CFG_FMT_LSB +: CFG_FMT_W];
  assign rtc_time        = state_reg.rtc;
  assign scr_base        = state_reg.scr_base;
  assign scr_ext         = state_reg.scr_ext;

endmodule : avc_video_packet_framer

// *** testbench/avc_video_packet_framer_chk.sv ***
`timescale 1ns/1ns
module avc_video_packet_framer_chk
  import avc_framer_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic                  clk,
  input wire logic                  arst_n,
  // Register bus.
  input wire logic                  read,
  input wire logic                  write,
  input wire logic                  waitrequest,
  // Stream ports.
  input wire logic                  in_valid,
  input wire logic                  in_ready,
  input wire logic [DATA_W-1:0]     out_data,
  input wire logic                  out_valid,
  input wire logic                  out_sop,
  input wire logic                  out_eop,
  input wire logic                  out_ready,
  // Time bases.
  input wire logic [RTC_W-1:0]      rtc_time,
  input wire logic [SCR_EXT_W-1:0]  scr_ext
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Everything lives in one domain, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_bus_answer_time: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
  a_bus_answer_once: assert property (!waitrequest |=> waitrequest) else $error("bus answer too long");
  a_chan_reserved: assert property (out_valid && out_sop |-> out_data[31:27] == 5'h00)
    else $error("reserved bits set");
  a_profile_legal: assert property (out_valid && out_sop |-> out_data[18:15] <= PROFILE_MAX)
    else $error("reserved profile emitted");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable({out_data, out_sop, out_eop}))
    else $error("output dropped while stalled");
  a_ready_spacing: assert property (in_valid && in_ready |=> !in_ready) else $error("input taken twice in a row");
  a_rtc_step: assert property ($changed(rtc_time) |-> rtc_time == $past(rtc_time) + 48'h1)
    else $error("time counter skipped");
  a_rtc_rate: assert property ($changed(rtc_time) |=> $stable(rtc_time) [*8])
    else $error("time counter too fast");
  a_scr_ext_mod: assert property (scr_ext < 9'h12c)
    else $error("extension beyond modulus");
endmodule : avc_video_packet_framer_chk

bind avc_video_packet_framer avc_video_packet_framer_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .arst_n(arst_n),
  .read(read), .write(write), .waitrequest(waitrequest), .in_valid(in_valid), .in_ready(in_ready),
  .out_data(out_data), .out_valid(out_valid), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready),
  .rtc_time(rtc_time), .scr_ext(scr_ext));

// *** testbench/stream_source_model.sv ***
`timescale 1ns/1ns
module stream_source_model (
  // Clock and reset.
  input wire logic         clk,
  input wire logic         arst_n,
  // Job from the bench.
  input wire logic         go,
  input wire logic         slow,
  input wire logic [7:0]   n_pkts,
  input wire logic [7:0]   n_words,
  input wire logic [31:0]  base,
  output logic             busy,
  // Stream towards the framer.
  output logic [31:0]      in_data,
  output logic             in_valid,
  output logic             in_sop,
  output logic             in_eop,
  input wire logic         in_ready
);
  int p, w, k, t;
  // Whole packets only; released data is inverted so stale words never look valid.
  initial begin
    busy = 1'b0; in_valid = 1'b0; in_sop = 1'b0; in_eop = 1'b0; in_data = 32'h0;
    forever begin
      @(posedge clk);
      if (go && arst_n) begin
        busy <= 1'b1;
        k = 0;
        for (p = 0; p < n_pkts; p++) begin
          for (w = 0; w < n_words; w++) begin
            in_data <= base + k;
            k++;
            in_valid <= 1'b1;
            in_sop <= (w == 0);
            in_eop <= (w == n_words - 1);
            t = 0;
            do begin @(posedge clk); t++; end while (in_ready !== 1'b1 && t < 1000);
            if (slow) begin
              in_valid <= 1'b0;
              in_data <= ~in_data;
              repeat (3) @(posedge clk);
            end
          end
          in_valid <= 1'b0;
          in_data <= ~in_data;
          @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : stream_source_model

// *** testbench/avc_video_packet_framer_tb.sv ***
`timescale 1ns/1ns
module avc_video_packet_framer_tb;
  import avc_framer_pkg::*;
  logic clk, arst_n, read, write, waitrequest, in_valid, in_sop, in_eop, in_ready, go, slow, busy;
  logic out_valid, out_sop, out_eop, out_ready, abs_time_select;
  logic [4:0] address;
  logic [31:0] writedata, readdata, in_data, out_data, base, cfg, rd, seed, rseed;
  logic [3:0] byteenable;
  logic [63:0] abs_time;
  logic [1:0] time_format;
  logic [47:0] rtc_time, t0;
  logic [32:0] scr_base;
  logic [8:0] scr_ext;
  logic [7:0] n_pkts, n_words;
  logic [65:0] q[$];
  logic [65:0] e;
  int n_mismatch, checks_done, i;

  avc_video_packet_framer #(.DATA_W(32)) u_dut (.clk, .arst_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .in_data, .in_valid, .in_sop, .in_eop, .in_ready, .abs_time, .out_data, .out_valid,
    .out_sop, .out_eop, .out_ready, .abs_time_select, .time_format, .rtc_time, .scr_base, .scr_ext);
  stream_source_model u_src (.clk, .arst_n, .go, .slow, .n_pkts, .n_words, .base, .busy, .in_data, .in_valid,
    .in_sop, .in_eop, .in_ready);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // One Avalon transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    address <= a; writedata <= d; read <= !w; write <= w; t = 0;
    do begin @(posedge clk); t++; end while (waitrequest !== 1'b0 && t < 100);
    rd = readdata; read <= 1'b0; write <= 1'b0;
    if (t >= 100) begin n_mismatch++; results(); end
    @(posedge clk);
  endtask : bus

  task automatic push(input logic [31:0] m, input logic s, input logic f, input logic [31:0] d);
    q.push_back({m, s, f, d & m});
  endtask : push

  // Notes one whole body, starts the source, then waits for it to drain.
  task automatic body(input logic [31:0] c, input int np, input int nw, input int cnt, input logic sl);
    int p, w, t;
    push('1, 1'b1, 1'b0, (c & 32'h07ff_f000) | cnt);
    for (p = 0; p < np; p++) begin
      if (c[19] && c[6]) begin push('1, 0, 0, abs_time[31:0]); push('1, 0, 0, abs_time[63:32]); end
      else if (c[19]) begin push(0, 0, 0, 0); push(32'hffff_0000, 0, 0, 0); end
      for (w = 0; w < nw; w++) push('1, 1'b0, (p == np - 1 && w == nw - 1), base + p * nw + w);
    end
    n_pkts <= np; n_words <= nw; slow <= sl; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0; t = 0;
    do begin @(posedge clk); t++; end while ((busy !== 1'b0 || q.size() != 0) && t < 3000);
    if (t >= 3000) begin n_mismatch++; results(); end
  endtask : body

  // ------------------------------------------------------------
  // Clock, downstream stalls and output monitor
  // ------------------------------------------------------------
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  // The assembler stalls about a quarter of the time to exercise holding.
  always @(posedge clk) begin
    rseed <= lfsr(rseed);
    out_ready <= rseed[0] | rseed[1];
  end
  always @(posedge clk) if (arst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
    if (q.size() == 0) check(34'h1, 34'h0);
    else begin
      e = q.pop_front();
      check({out_sop, out_eop, out_data & e[65:34]}, e[33:0]);
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0; read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0; byteenable = 4'hf;
    out_ready = 1'b0; go = 1'b0; slow = 1'b0; n_pkts = 8'h01; n_words = 8'h01; base = 32'h0;
    seed = 32'd79311; rseed = 32'd79311; abs_time = {32'd79311, ~32'd79311};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, OFS_CONFIG, 0); check(rd, 0);
    bus(0, OFS_LIMIT, 0); check(rd, 0);
    bus(0, 5'h1c, 0); check(rd, 0);
    bus(1, OFS_LIMIT, 1);
    // Every level code, every legal profile, both time sources, stamps on and off.
    for (i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      base <= seed;
      cfg = (seed & 32'h0430_700d) | (32'(i) << 22) | (32'(i % 7) << 15) | (32'(i & 1) << 19) | (32'((i >> 1) & 1) << 6);
      bus(1, OFS_CONFIG, cfg);
      check({abs_time_select, time_format}, {cfg[6], cfg[3:2]});
      body(cfg, 1, 1 + i % 3, 1, i[2]);
    end
    bus(1, OFS_CONFIG, cfg | 32'h0003_8000);
    bus(0, OFS_CONFIG, 0);
    check(rd[18:15], cfg[18:15]);
    bus(0, OFS_STATUS, 0);
    check(rd[2], 1'b1);
    bus(1, OFS_LIMIT, 3);
    cfg = cfg | 32'h0008_0040;
    bus(1, OFS_CONFIG, cfg);
    body(cfg, 3, 2, 3, 1'b0);
    bus(1, OFS_LIMIT, 0);
    bus(1, OFS_CONTROL, 1);
    cfg = cfg & ~32'h0008_0000;
    bus(1, OFS_CONFIG, cfg);
    body(cfg, 1, 2, 0, 1'b1);
    // A reader turns the reference back into time ticks, ten over twenty-seven, rounded.
    bus(1, OFS_CONFIG, 0);
    bus(1, OFS_CONFIG, 1);
    t0 = rtc_time;
    repeat (1500) @(posedge clk);
    check(34'(((64'(scr_base) * 300 + scr_ext) * 20 + 27) / 54), 34'(rtc_time - t0));
    results();
  end
endmodule : avc_video_packet_framer_tb
